// ==== design/dspdec_decoder.sv ====
// Partial instruction decoder for the fixed-point signal processor core.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RULE_01] Byte E3 is a two-word conditional branch; 4 cycles taken, 2 not.
// [RULE_02] Branch-if-nonzero uses condition byte 08; zero must be false.
// [RULE_03] Branch-if-zero uses condition byte 88: zero tested, must be true.
// [RULE_04] Branch-on-overflow uses condition byte 22; taken on overflow.
// [RULE_05] Top nibble 4 tests the bit chosen by bits 11..8, one cycle.
// [RULE_06] Byte 6F tests the operand bit chosen by the temporary register.
// [RULE_07] Bytes A8 and A9 are two-word data block moves, three cycles.
// [RULE_08] Software keeps data block moves off mapped interrupt registers.
// [RULE_09] Byte A5 is a two-word program-to-data block move, three cycles.
// [RULE_10] BE30 calls via accumulator; byte 7A calls direct; both 4 cycles.
// [RULE_11] Prefix 111010 is a two-word conditional call, 4 or 2 cycles.
// [RULE_12] BE44 configures the block as data memory; BE40 enables interrupts.
// [RULE_13] BE4C clears the external flag bit.
// [RULE_14] BE01 complements the accumulator in one cycle.
// [RULE_15] BF44..BF47 compare auxiliary register with register zero.
// [RULE_16] Byte 77 copies a data word to the next address, one cycle.
// [RULE_17] BE22 halts execution in low power until an interrupt; here idle holds until reset.
// [RULE_18] Port input is two words, two cycles, second word is port address.
// [RULE_19] BE60..BE7F raise a software interrupt to the vector, 4 cycles.
// [RULE_20] Top nibble 1 loads the accumulator from memory with shift.
// [RULE_21] BF8x loads the accumulator with the shifted following constant.
// [RULE_22] Byte 6A zeroes low accumulator and loads the high half.
// [RULE_23] Select pair: 0 pin low, 1 flag set, 2 flag clear, 3 none.
// [RULE_24] Low nibble masks tested flags, bits 7..4 hold wanted states.
// [RULE_25] Unknown words are illegal and leave architectural state unchanged.
module dspdec_decoder #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic word_valid_in,
	input wire logic [WIDTH-1:0] word_in,
	input wire dspdec_pkg::dspdec_flags_s flags_in,
	output dspdec_pkg::dspdec_ctrl_s ctrl_out,
	output logic ctrl_valid_out,
	output logic illegal_out,
	output logic data_memory_mode_out,
	output logic interrupts_enabled_out,
	output logic external_flag_out,
	output logic idle_out,
	output logic interrupt_wake_in_dummy_out
);
	import dspdec_pkg::*;

	// The decode widths are fixed by the instruction format.
	if (WIDTH != WORD_W) begin : g_bad_width
		$error("dspdec_decoder: WIDTH must equal the instruction width");
	end

	// Returns the cycle count of a conditional form.
	function automatic logic [2:0] cond_cycles(input logic met);
		cond_cycles = met ? CYC_4 : CYC_2;
	endfunction

	// Pattern matching on the first word, continuous and prioritized.
	logic [15:0] w;
	logic is_cbr;
	logic is_ccall;
	logic cond_met;
	assign w = word_in[15:0];
	assign is_cbr = w[15:8] == OP_COND_BRANCH; // [RULE_01]
	assign is_ccall = w[15:10] == OP_COND_CALL; // [RULE_11]

	// Masked compare covers the nonzero, zero and overflow byte forms.
	dspdec_cond_eval u_cond (
		.condition_flag_field_in(w[7:0]), // [RULE_02] [RULE_03] [RULE_04]
		.condition_select_pair_in(w[POS_SEL+1:POS_SEL]),
		.use_select_in(is_ccall),
		.flags_in(flags_in),
		.met_out(cond_met)
	);

	// Operation selection; earlier matches win over later ones.
	dspdec_op_e next_op;
	assign next_op =
		is_cbr ? DSPDEC_COND_BRANCH :
		is_ccall ? DSPDEC_COND_CALL :
		(w == OP_ACC_CALL) ? DSPDEC_ACC_CALL : // [RULE_10]
		(w == OP_CFG_DATA) ? DSPDEC_CFG_DATA : // [RULE_12]
		(w == OP_INT_ENABLE) ? DSPDEC_INT_ENABLE : // [RULE_12]
		(w == OP_CLR_XF) ? DSPDEC_CLR_XF : // [RULE_13]
		(w == OP_ACC_INVERT) ? DSPDEC_ACC_INVERT : // [RULE_14]
		(w == OP_IDLE) ? DSPDEC_IDLE : // [RULE_17]
		(w[15:2] == OP_AUX_COMPARE) ? DSPDEC_AUX_COMPARE : // [RULE_15]
		(w[15:5] == OP_SW_TRAP) ? DSPDEC_SW_TRAP : // [RULE_19]
		(w[15:4] == OP_ACC_LOAD_IMM) ? DSPDEC_ACC_LOAD_IMM : // [RULE_21]
		(w[15:12] == OP_BIT_TEST) ? DSPDEC_BIT_TEST : // [RULE_05]
		(w[15:8] == OP_REG_BIT_TEST) ? DSPDEC_REG_BIT_TEST : // [RULE_06]
		(w[15:8] == OP_BLOCK_SRC_IMM) ? DSPDEC_BLOCK_SRC_IMM : // [RULE_07]
		(w[15:8] == OP_BLOCK_DST_IMM) ? DSPDEC_BLOCK_DST_IMM : // [RULE_07]
		(w[15:8] == OP_BLOCK_PROG) ? DSPDEC_BLOCK_PROG : // [RULE_09]
		(w[15:8] == OP_DIRECT_CALL) ? DSPDEC_DIRECT_CALL : // [RULE_10]
		(w[15:8] == OP_DATA_COPY) ? DSPDEC_DATA_COPY : // [RULE_16]
		(w[15:8] == OP_PORT_IN) ? DSPDEC_PORT_IN : // [RULE_18]
		(w[15:12] == OP_ACC_LOAD_SHIFT) ? DSPDEC_ACC_LOAD_SHIFT : // [RULE_20]
		(w[15:8] == OP_ZERO_LOW_LOAD) ? DSPDEC_ZERO_LOW_LOAD : // [RULE_22]
		DSPDEC_ILLEGAL; // [RULE_25]

	// Words, cycles and condition for the selected operation.
	logic next_two_word;
	logic [2:0] next_cycles;
	always_comb begin
		next_two_word = 1'b0;
		next_cycles = CYC_1;
		case (next_op)
			DSPDEC_COND_BRANCH, DSPDEC_COND_CALL: begin
				next_two_word = 1'b1;
				next_cycles = cond_cycles(cond_met); // [RULE_01] [RULE_11]
			end
			DSPDEC_BLOCK_SRC_IMM, DSPDEC_BLOCK_DST_IMM,
			DSPDEC_BLOCK_PROG: begin
				next_two_word = 1'b1;
				next_cycles = CYC_3; // [RULE_07] [RULE_09]
			end
			DSPDEC_DIRECT_CALL: begin
				next_two_word = 1'b1;
				next_cycles = CYC_4; // [RULE_10]
			end
			DSPDEC_ACC_CALL, DSPDEC_SW_TRAP: begin
				next_cycles = CYC_4; // [RULE_10] [RULE_19]
			end
			DSPDEC_PORT_IN: begin
				next_two_word = 1'b1;
				next_cycles = CYC_2; // [RULE_18]
			end
			DSPDEC_ACC_LOAD_IMM: begin
				next_two_word = 1'b1;
				next_cycles = CYC_2; // [RULE_21]
			end
			DSPDEC_ILLEGAL, DSPDEC_NOP: begin
				next_cycles = CYC_1;
			end
			default: begin
				next_cycles = CYC_1;
			end
		endcase
	end

	// Packed control word assembled from the decoded fields.
	dspdec_ctrl_s next_ctrl;
	logic next_writes;
	assign next_writes = next_op != DSPDEC_ILLEGAL; // [RULE_25]
	assign next_ctrl = '{op: next_op, two_word: next_two_word,
		cycles: next_cycles,
		cond_true: (is_cbr || is_ccall) && cond_met,
		field: w[POS_FIELD_HI:POS_FIELD_LO], // [RULE_05]
		trap_vector: w[4:0], // [RULE_19]
		compare_type_field: w[1:0], // [RULE_15]
		writes_state: next_writes};

	// Second word of a two-word instruction is operand, never decoded.
	logic second_pending;
	logic decode_now;
	assign decode_now = word_valid_in && !second_pending && !idle_out;

	// Decode pipeline register and second-word tracking.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			ctrl_out <= '0;
			ctrl_valid_out <= 1'b0;
			illegal_out <= 1'b0;
			second_pending <= 1'b0;
		end else begin
			ctrl_valid_out <= decode_now;
			illegal_out <= decode_now && (next_op == DSPDEC_ILLEGAL);
			if (decode_now) begin
				ctrl_out <= next_ctrl;
				second_pending <= next_two_word; // [RULE_18]
			end else if (word_valid_in) begin
				second_pending <= 1'b0;
			end
		end
	end

	// Status bits that single-word control forms change.
	logic do_cfg;
	logic do_ie;
	logic do_xf;
	logic do_idle;
	assign do_cfg = decode_now && next_op == DSPDEC_CFG_DATA;
	assign do_ie = decode_now && next_op == DSPDEC_INT_ENABLE;
	assign do_xf = decode_now && next_op == DSPDEC_CLR_XF;
	assign do_idle = decode_now && next_op == DSPDEC_IDLE;

	// Control bits; idle holds until reset, as no wake input reaches here.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			data_memory_mode_out <= 1'b0;
			interrupts_enabled_out <= 1'b0;
			external_flag_out <= 1'b1;
			idle_out <= 1'b0;
			interrupt_wake_in_dummy_out <= 1'b0;
		end else begin
			if (do_cfg) begin
				data_memory_mode_out <= 1'b1; // [RULE_12]
			end
			if (do_ie) begin
				interrupts_enabled_out <= 1'b1; // [RULE_12]
			end
			if (do_xf) begin
				external_flag_out <= 1'b0; // [RULE_13]
			end
			if (do_idle) begin
				idle_out <= 1'b1; // [RULE_17]
			end
			interrupt_wake_in_dummy_out <= 1'b0;
		end
	end
endmodule // dspdec_decoder
`default_nettype wire

// ==== design/dspdec_pkg.sv ====
// Package with the opcode patterns, field positions and decode types.
package dspdec_pkg;
	localparam int WORD_W = 16;
	// Cycle counts of the decoded instructions.
	localparam logic [2:0] CYC_1 = 3'h1;
	localparam logic [2:0] CYC_2 = 3'h2;
	localparam logic [2:0] CYC_3 = 3'h3;
	localparam logic [2:0] CYC_4 = 3'h4;
	// Fixed opcode bytes and words.
	localparam logic [7:0] OP_COND_BRANCH = 8'hE3;
	localparam logic [5:0] OP_COND_CALL = 6'h3A;
	localparam logic [3:0] OP_BIT_TEST = 4'h4;
	localparam logic [7:0] OP_REG_BIT_TEST = 8'h6F;
	localparam logic [7:0] OP_BLOCK_SRC_IMM = 8'hA8;
	localparam logic [7:0] OP_BLOCK_DST_IMM = 8'hA9;
	localparam logic [7:0] OP_BLOCK_PROG = 8'hA5;
	localparam logic [15:0] OP_ACC_CALL = 16'hBE30;
	localparam logic [7:0] OP_DIRECT_CALL = 8'h7A;
	localparam logic [15:0] OP_CFG_DATA = 16'hBE44;
	localparam logic [15:0] OP_INT_ENABLE = 16'hBE40;
	localparam logic [15:0] OP_CLR_XF = 16'hBE4C;
	localparam logic [15:0] OP_ACC_INVERT = 16'hBE01;
	localparam logic [13:0] OP_AUX_COMPARE = 14'h2FD1;
	localparam logic [7:0] OP_DATA_COPY = 8'h77;
	localparam logic [15:0] OP_IDLE = 16'hBE22;
	localparam logic [7:0] OP_PORT_IN = 8'hAF;
	localparam logic [10:0] OP_SW_TRAP = 11'h5F3;
	localparam logic [3:0] OP_ACC_LOAD_SHIFT = 4'h1;
	localparam logic [11:0] OP_ACC_LOAD_IMM = 12'hBF8;
	localparam logic [7:0] OP_ZERO_LOW_LOAD = 8'h6A;
	// Condition-select pair codes.
	localparam logic [1:0] SEL_PIN_LOW = 2'h0;
	localparam logic [1:0] SEL_FLAG_SET = 2'h1;
	localparam logic [1:0] SEL_FLAG_CLEAR = 2'h2;
	// Field positions inside the first word.
	localparam int POS_FIELD_HI = 11;
	localparam int POS_FIELD_LO = 8;
	localparam int POS_SEL = 8;

	// Decoded operation kinds.
	typedef enum logic [4:0] {
		DSPDEC_NOP,
		DSPDEC_COND_BRANCH,
		DSPDEC_BIT_TEST,
		DSPDEC_REG_BIT_TEST,
		DSPDEC_BLOCK_SRC_IMM,
		DSPDEC_BLOCK_DST_IMM,
		DSPDEC_BLOCK_PROG,
		DSPDEC_ACC_CALL,
		DSPDEC_DIRECT_CALL,
		DSPDEC_COND_CALL,
		DSPDEC_CFG_DATA,
		DSPDEC_INT_ENABLE,
		DSPDEC_CLR_XF,
		DSPDEC_ACC_INVERT,
		DSPDEC_AUX_COMPARE,
		DSPDEC_DATA_COPY,
		DSPDEC_IDLE,
		DSPDEC_PORT_IN,
		DSPDEC_SW_TRAP,
		DSPDEC_ACC_LOAD_SHIFT,
		DSPDEC_ACC_LOAD_IMM,
		DSPDEC_ZERO_LOW_LOAD,
		DSPDEC_ILLEGAL
	} dspdec_op_e;

	// Status flags that conditional forms test.
	typedef struct packed {
		logic zero;
		logic negative;
		logic overflow;
		logic carry;
		logic test_control_flag;
		logic branch_input_pin_low;
	} dspdec_flags_s;

	// Execute controls issued for one decoded instruction.
	typedef struct packed {
		dspdec_op_e op;
		logic two_word;
		logic [2:0] cycles;
		logic cond_true;
		logic [3:0] field;
		logic [4:0] trap_vector;
		logic [1:0] compare_type_field;
		logic writes_state;
	} dspdec_ctrl_s;
endpackage : dspdec_pkg

// ==== design/dspdec_cond_eval.sv ====
// Condition evaluator for conditional branch and call forms.
`timescale 1ns/1ns
`default_nettype none
module dspdec_cond_eval (
	input wire logic [7:0] condition_flag_field_in,
	input wire logic [1:0] condition_select_pair_in,
	input wire logic use_select_in,
	input wire dspdec_pkg::dspdec_flags_s flags_in,
	output logic met_out
);
	import dspdec_pkg::*;

	// Masked flag comparison: each tested flag must match its wanted state.
	logic [3:0] mask;
	logic [3:0] want;
	logic [3:0] have;
	logic flags_ok;
	logic sel_ok;
	assign mask = condition_flag_field_in[3:0];
	assign want = condition_flag_field_in[7:4];
	assign have = {flags_in.zero, flags_in.negative, flags_in.overflow,
		flags_in.carry};
	assign flags_ok = ((have ^ want) & mask) == 4'h0; // [RULE_24]

	// Pair select adds the pin or test flag condition.
	assign sel_ok = (condition_select_pair_in == SEL_PIN_LOW) ?
		flags_in.branch_input_pin_low :
		(condition_select_pair_in == SEL_FLAG_SET) ?
		flags_in.test_control_flag :
		(condition_select_pair_in == SEL_FLAG_CLEAR) ?
		!flags_in.test_control_flag : 1'b1; // [RULE_23]
	assign met_out = flags_ok && (sel_ok || !use_select_in);
endmodule // dspdec_cond_eval
`default_nettype wire

// ==== verification/dspdec_props.sv ====
// Checker of decode timing and status side effects at the decoder ports.
`timescale 1ns/1ns
`default_nettype none
module dspdec_props (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic word_valid_in,
	input wire logic [15:0] word_in,
	input wire dspdec_pkg::dspdec_flags_s flags_in,
	input wire dspdec_pkg::dspdec_ctrl_s ctrl_out,
	input wire logic ctrl_valid_out,
	input wire logic illegal_out,
	input wire logic data_memory_mode_out,
	input wire logic interrupts_enabled_out,
	input wire logic external_flag_out,
	input wire logic idle_out
);
	import dspdec_pkg::*;
	logic pend;
	// An opcode word is one that is neither an operand nor refused.
	wire logic takes_op = ctrl_valid_out && ctrl_out.two_word;
	wire logic first = word_valid_in && !idle_out && !pend && !takes_op;
	// Remembers a two-word opcode whose operand has not yet arrived.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in || word_valid_in)
			pend <= 1'b0;
		else if (takes_op)
			pend <= 1'b1;
	end
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rstn_in);
	property p_lat; first |=> ctrl_valid_out; endproperty
	a_lat: assert property (p_lat) else $error("no answer");
	property p_opnd; word_valid_in && !first |=> !ctrl_valid_out; endproperty
	a_opnd: assert property (p_opnd) else $error("operand decoded");
	property p_inv;
		first && word_in == OP_ACC_INVERT |=>
			ctrl_out.op == DSPDEC_ACC_INVERT && ctrl_out.cycles == CYC_1;
	endproperty
	a_inv: assert property (p_inv) else $error("invert bad");
	property p_nz;
		first && word_in == 16'hE308 |=>
			ctrl_out.cycles == ($past(flags_in.zero) ? CYC_2 : CYC_4);
	endproperty
	a_nz: assert property (p_nz) else $error("nonzero branch bad");
	property p_cfg;
		first && word_in == OP_CFG_DATA |=> data_memory_mode_out;
	endproperty
	a_cfg: assert property (p_cfg) else $error("data mode unset");
	property p_ie;
		first && word_in == OP_INT_ENABLE |=> interrupts_enabled_out [*3];
	endproperty
	a_ie: assert property (p_ie) else $error("int enable bad");
	property p_xf;
		first && word_in == OP_CLR_XF |=> !external_flag_out;
	endproperty
	a_xf: assert property (p_xf) else $error("flag not cleared");
	property p_idle; idle_out |=> !ctrl_valid_out && idle_out; endproperty
	a_idle: assert property (p_idle) else $error("idle broken");
	property p_ill;
		illegal_out |-> ctrl_valid_out && !ctrl_out.writes_state &&
			$stable(data_memory_mode_out) && $stable(external_flag_out);
	endproperty
	a_ill: assert property (p_ill) else $error("illegal changed state");
	property p_trap;
		logic [4:0] v;
		(first && word_in[15:5] == OP_SW_TRAP, v = word_in[4:0]) |=>
			ctrl_out.trap_vector == v && ctrl_out.cycles == CYC_4;
	endproperty
	a_trap: assert property (p_trap) else $error("trap bad");
endmodule // dspdec_props
`default_nettype wire

// ==== verification/dspdec_fetch_model.sv ====
// Fetch-side model that presents instruction words to the decoder.
`timescale 1ns/1ns
`default_nettype none
module dspdec_fetch_model (
	input wire logic sys_clk_in,
	input wire logic send_in,
	input wire logic [15:0] req_word_in,
	output logic word_valid_out,
	output logic [15:0] word_out
);
	logic [15:0] last = 16'h0000;
	// A released word bus shows the inverse of the last word sent.
	assign word_valid_out = send_in;
	assign word_out = send_in ? req_word_in : ~last;
	// Keeps the last word sent.
	always @(posedge sys_clk_in) begin
		if (send_in)
			last <= req_word_in;
	end
endmodule // dspdec_fetch_model
`default_nettype wire

// ==== verification/dspdec_decoder_bench.sv ====
// Self-checking bench for the partial instruction decoder.
`timescale 1ns/1ns
`default_nettype none
module dspdec_decoder_bench;
	import dspdec_pkg::*;
	logic sys_clk_in, rstn_in, send, word_valid_in, ctrl_valid_out, illegal_out;
	logic data_memory_mode_out, interrupts_enabled_out, external_flag_out;
	logic idle_out, interrupt_wake_in_dummy_out;
	logic [15:0] req, word_in;
	dspdec_flags_s flags_in;
	dspdec_ctrl_s ctrl_out;
	int n_fail = 0;
	int checks_done = 0;
	dspdec_fetch_model u_fetch (.sys_clk_in, .send_in(send), .req_word_in(req),
		.word_valid_out(word_valid_in), .word_out(word_in));
	dspdec_decoder #(.WIDTH(16)) DUT (.sys_clk_in, .rstn_in, .word_valid_in,
		.word_in, .flags_in, .ctrl_out, .ctrl_valid_out, .illegal_out,
		.data_memory_mode_out, .interrupts_enabled_out, .external_flag_out,
		.idle_out, .interrupt_wake_in_dummy_out);
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %0h want %0h", $time, seen, exp);
		end
	endtask
	// Sends one opcode, plus its operand straight after when two words long.
	task dec(input logic [15:0] w, input logic two, input dspdec_op_e op,
		input logic [2:0] cyc);
		@(negedge sys_clk_in);
		send = 1'b1;
		req = w;
		@(negedge sys_clk_in);
		if (two)
			req = 16'h0300;
		else
			send = 1'b0;
		chk(ctrl_valid_out, 1);
		chk(ctrl_out.op, op);
		chk(ctrl_out.two_word, two);
		if (cyc != 3'h0)
			chk(ctrl_out.cycles, cyc);
		if (two) begin
			@(negedge sys_clk_in);
			send = 1'b0;
			chk(ctrl_valid_out, 0);
		end
	endtask
	task cnd(input logic [15:0] w, input logic [5:0] f, input logic [2:0] cyc);
		flags_in = f;
		dec(w, 1'b1, w[15:10] == OP_COND_CALL ? DSPDEC_COND_CALL :
			DSPDEC_COND_BRANCH, cyc);
		chk(ctrl_out.cond_true, cyc == CYC_4);
	endtask
	task t_status;
		chk(external_flag_out, 1);
		chk({data_memory_mode_out, interrupts_enabled_out, idle_out}, 0);
		dec(16'hFFFF, 1'b0, DSPDEC_ILLEGAL, 3'h0);
		chk({illegal_out, ctrl_out.writes_state, external_flag_out}, 3'h5);
		chk(data_memory_mode_out, 0);
		dec(16'hBE44, 1'b0, DSPDEC_CFG_DATA, CYC_1);
		dec(16'hBE40, 1'b0, DSPDEC_INT_ENABLE, CYC_1);
		dec(16'hBE4C, 1'b0, DSPDEC_CLR_XF, CYC_1);
		chk({data_memory_mode_out, interrupts_enabled_out}, 3);
		chk({external_flag_out, interrupt_wake_in_dummy_out}, 0);
		$display("status test done");
	endtask
	task t_single;
		dec(16'hBE01, 1'b0, DSPDEC_ACC_INVERT, CYC_1);
		dec(16'hBE30, 1'b0, DSPDEC_ACC_CALL, CYC_4);
		dec(16'h4A00, 1'b0, DSPDEC_BIT_TEST, CYC_1);
		chk(ctrl_out.field, 4'hA);
		dec(16'h6F00, 1'b0, DSPDEC_REG_BIT_TEST, CYC_1);
		dec(16'h7700, 1'b0, DSPDEC_DATA_COPY, CYC_1);
		dec(16'h1500, 1'b0, DSPDEC_ACC_LOAD_SHIFT, 3'h0);
		chk(ctrl_out.field, 4'h5);
		dec(16'h6A00, 1'b0, DSPDEC_ZERO_LOW_LOAD, CYC_1);
		dec(16'hBF46, 1'b0, DSPDEC_AUX_COMPARE, CYC_1);
		chk(ctrl_out.compare_type_field, 2'h2);
		dec(16'hBE7F, 1'b0, DSPDEC_SW_TRAP, CYC_4);
		chk(ctrl_out.trap_vector, 5'h1F);
		$display("single-word test done");
	endtask
	// Block move operands point at plain data memory, not mapped registers.
	task t_two;
		dec(16'hA811, 1'b1, DSPDEC_BLOCK_SRC_IMM, CYC_3);
		dec(16'hA911, 1'b1, DSPDEC_BLOCK_DST_IMM, CYC_3);
		dec(16'hA511, 1'b1, DSPDEC_BLOCK_PROG, CYC_3);
		dec(16'h7A10, 1'b1, DSPDEC_DIRECT_CALL, CYC_4);
		dec(16'hAF10, 1'b1, DSPDEC_PORT_IN, CYC_2);
		dec(16'hBF83, 1'b1, DSPDEC_ACC_LOAD_IMM, 3'h0);
		$display("two-word test done");
	endtask
	task t_cond;
		cnd(16'hE308, 6'h00, CYC_4);
		cnd(16'hE308, 6'h20, CYC_2);
		cnd(16'hE388, 6'h20, CYC_4);
		cnd(16'hE388, 6'h00, CYC_2);
		cnd(16'hE322, 6'h08, CYC_4);
		cnd(16'hE322, 6'h00, CYC_2);
		cnd(16'hE311, 6'h04, CYC_4);
		cnd(16'hE304, 6'h10, CYC_2);
		cnd(16'hE888, 6'h21, CYC_4);
		cnd(16'hE888, 6'h20, CYC_2);
		cnd(16'hE988, 6'h22, CYC_4);
		cnd(16'hE988, 6'h20, CYC_2);
		cnd(16'hEA88, 6'h20, CYC_4);
		cnd(16'hEB88, 6'h00, CYC_2);
		$display("condition test done");
	endtask
	task t_idle;
		dec(16'hBE22, 1'b0, DSPDEC_IDLE, 3'h0);
		chk(idle_out, 1);
		dec_refused(16'hBE01);
		rstn_in = 1'b0;
		repeat (2) @(negedge sys_clk_in);
		rstn_in = 1'b1;
		chk({idle_out, external_flag_out}, 1);
		$display("idle test done");
	endtask
	task dec_refused(input logic [15:0] w);
		@(negedge sys_clk_in);
		send = 1'b1;
		req = w;
		@(negedge sys_clk_in);
		send = 1'b0;
		chk(ctrl_valid_out, 0);
	endtask
	// Free-running 10 MHz clock.
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end
	// Main sequence after a two-cycle reset.
	initial begin
		rstn_in = 1'b0;
		send = 1'b0;
		req = 16'h0000;
		flags_in = '0;
		repeat (2) @(negedge sys_clk_in);
		rstn_in = 1'b1;
		t_status;
		t_single;
		t_two;
		t_cond;
		t_idle;
		complete_run;
	end
	// The tests need about 100 cycles; the watchdog allows 1000.
	initial begin
		#100000;
		n_fail++;
		complete_run;
	end
endmodule // dspdec_decoder_bench
bind dspdec_decoder dspdec_props u_props (.sys_clk_in, .rstn_in, .word_valid_in,
	.word_in, .flags_in, .ctrl_out, .ctrl_valid_out, .illegal_out,
	.data_memory_mode_out, .interrupts_enabled_out, .external_flag_out, .idle_out);
`default_nettype wire
